// >>> logic/pws_pkg.sv
package pws_pkg;
  // Clock and the one-second supervision timebase
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned TICK_S = 1;
  localparam int unsigned SEC_CYCLES = CLK_HZ * TICK_S;
  localparam int unsigned TICK_W = 26;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_WDG_CTRL = 8'h69;
  localparam logic [7:0] IDX_BOOT_VER = 8'h6a;
  localparam logic [7:0] IDX_SPARE = 8'h6b;
  localparam logic [7:0] IDX_WDG_STATUS = 8'h70;

  // watchdog_control fields
  localparam int unsigned MODE_BIT = 3;
  localparam int unsigned TIME_LSB = 0;
  localparam logic MODE_RST = 1'b0;
  localparam logic [2:0] TIME_RST = 3'h0;
  localparam logic MODE_PERIODIC = 1'b0;
  localparam logic MODE_PENDING = 1'b1;

  // boot_sequence_version and reserved_spare fields
  localparam int unsigned BOOT_LSB = 1;
  localparam logic [4:0] BOOT_RST = 5'h00;
  localparam logic [5:0] SPARE_RST = 6'h00;

  // Status register fields, write one to clear
  localparam int unsigned STAT_IRQ_BIT = 0;
  localparam int unsigned STAT_SHDN_BIT = 1;

  // Period choices in seconds
  localparam logic [6:0] PER_OFF = 7'h00;
  localparam logic [6:0] PER_5 = 7'h05;
  localparam logic [6:0] PER_10 = 7'h0a;
  localparam logic [6:0] PER_20 = 7'h14;
  localparam logic [6:0] PER_40 = 7'h28;
  localparam logic [6:0] PER_60 = 7'h3c;
  localparam logic [6:0] PER_80 = 7'h50;
  localparam logic [6:0] PER_100 = 7'h64;

  // Decode of the three-bit period field
  function automatic logic [6:0] pws_period_s(input logic [2:0] sel);
    unique case (sel)
      3'h0: pws_period_s = PER_OFF;
      3'h1: pws_period_s = PER_5;
      3'h2: pws_period_s = PER_10;
      3'h3: pws_period_s = PER_20;
      3'h4: pws_period_s = PER_40;
      3'h5: pws_period_s = PER_60;
      3'h6: pws_period_s = PER_80;
      3'h7: pws_period_s = PER_100;
    endcase
  endfunction : pws_period_s
endpackage : pws_pkg

// >>> logic/pws_tick_div.sv
`timescale 1ns/1ns
module pws_tick_div #(
  parameter int unsigned TICK_CYCLES = pws_pkg::SEC_CYCLES
) (
  input wire logic clk, // System clock
  input wire logic rst, // Async reset, active high
  input wire logic run, // Count only while supervising
  input wire logic restart, // Begin a fresh second
  output logic tick // One-cycle pulse per second
);
  import pws_pkg::*;

  localparam logic [TICK_W-1:0] LAST = TICK_W'(TICK_CYCLES - 1);

  logic [TICK_W-1:0] cnt;
  logic [TICK_W-1:0] next_cnt;

  ////////////////////////////////////////////////////////////////////////
  // Restart aligns the second boundary with the start of supervision
  always_comb begin
    tick = run && !restart && (cnt == LAST);
    if (restart || !run || tick) begin
      next_cnt = '0;
    end else begin
      next_cnt = cnt + TICK_W'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end
endmodule : pws_tick_div

// >>> logic/pws_top.sv
// Contract
// - Mode bit picks periodic (0) or pending supervision (1); resets to 0.
// - Periodic mode raises the watchdog interrupt once every selected period.
// - Periodic interrupt still set when the next period ends causes shutdown.
// - Pending mode shuts down when an interrupt stays pending a full period.
// - Period field: 0 off, then 5,10,20,40,60,80,100 seconds.
`timescale 1ns/1ns
module pws_top #(
  parameter int unsigned TICK_CYCLES = pws_pkg::SEC_CYCLES
) (
  input wire logic clk, // 50 MHz system clock
  input wire logic rst, // Async reset, active high
  input wire logic [9:0] address, // Avalon byte address
  input wire logic read, // Avalon read
  input wire logic write, // Avalon write
  input wire logic [31:0] writedata, // Avalon write data
  input wire logic [3:0] byteenable, // Avalon byte enables
  output logic [31:0] readdata, // Avalon read data, registered
  output logic waitrequest, // Avalon stall
  input wire logic irq_pending, // Any device interrupt pending
  output logic wdog_irq, // Watchdog interrupt level
  output logic timeout_shutdown // One-cycle shutdown request
);
  import pws_pkg::*;

  logic done, next_done;
  logic [31:0] next_readdata;
  logic supervision_mode_select, next_mode;
  logic [2:0] timeout_period_select, next_time;
  logic [4:0] boot_sequence_version_field, next_boot;
  logic [5:0] spare, next_spare;
  logic irq_flag, next_irq_flag;
  logic shdn_seen, next_shdn_seen;
  logic next_shutdown;
  logic [6:0] secs, next_secs;
  logic [6:0] period;
  logic tick, restart, ctrl_wr, stat_wr, irq_clr, shdn_clr, elapsed;
  logic [7:0] idx;

  ////////////////////////////////////////////////////////////////////////
  // Bus decode: one wait state, so read data can come from a flop
  assign idx = address[9:2];
  assign waitrequest = (read || write) && !done;
  assign ctrl_wr = write && done && byteenable[0] && idx == IDX_WDG_CTRL;
  assign stat_wr = write && done && byteenable[0] && idx == IDX_WDG_STATUS;
  assign irq_clr = stat_wr && writedata[STAT_IRQ_BIT];
  assign shdn_clr = stat_wr && writedata[STAT_SHDN_BIT];
  assign period = pws_period_s(timeout_period_select);

  // Count restarts: new setting, host clear, period off, idle pending line, or after shutdown
  assign restart = ctrl_wr || irq_clr || timeout_shutdown || period == PER_OFF
    || (supervision_mode_select == MODE_PENDING && !irq_pending);
  assign elapsed = tick && (secs + 7'h01 == period);

  pws_tick_div #(.TICK_CYCLES(TICK_CYCLES)) u_div (
    .clk(clk),
    .rst(rst),
    .run(period != PER_OFF),
    .restart(restart),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Register file and supervision next-state
  always_comb begin
    next_done = (read || write) && !done;
    next_readdata = readdata;
    next_mode = supervision_mode_select;
    next_time = timeout_period_select;
    next_boot = boot_sequence_version_field;
    next_spare = spare;
    next_irq_flag = irq_flag;
    next_shdn_seen = shdn_seen;
    next_shutdown = 1'b0;
    next_secs = secs;
    // Read data captured on the stall cycle, held through the answer
    if (read && !done) begin
      unique case (idx)
        IDX_WDG_CTRL: next_readdata = {28'h0, supervision_mode_select, timeout_period_select};
        IDX_BOOT_VER: next_readdata = {26'h0, boot_sequence_version_field, 1'b0};
        IDX_SPARE: next_readdata = {26'h0, spare};
        IDX_WDG_STATUS: next_readdata = {30'h0, shdn_seen, irq_flag};
        default: next_readdata = 32'h0; // Unmapped reads as zero
      endcase
    end
    if (ctrl_wr) begin
      next_mode = writedata[MODE_BIT];
      next_time = writedata[TIME_LSB +: 3];
    end
    if (write && done && byteenable[0] && idx == IDX_BOOT_VER) begin
      next_boot = writedata[BOOT_LSB +: 5];
    end
    if (write && done && byteenable[0] && idx == IDX_SPARE) begin
      next_spare = writedata[5:0];
    end
    if (irq_clr) begin
      next_irq_flag = 1'b0;
    end
    if (shdn_clr) begin
      next_shdn_seen = 1'b0;
    end
    if (tick) begin
      next_secs = secs + 7'h01;
    end
    if (elapsed && supervision_mode_select == MODE_PERIODIC) begin
      next_secs = 7'h00;
      // A clear landing on the elapse cycle counts as in time
      if (irq_flag && !irq_clr) begin
        next_shutdown = 1'b1;
      end else begin
        next_irq_flag = 1'b1;
      end
    end
    if (elapsed && supervision_mode_select == MODE_PENDING && irq_pending) begin
      next_shutdown = 1'b1;
    end
    if (next_shutdown) begin
      next_shdn_seen = 1'b1; // Set wins over a same-cycle clear
    end
    if (restart) begin
      next_secs = 7'h00;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done <= 1'b0;
      readdata <= 32'h0;
      supervision_mode_select <= MODE_RST;
      timeout_period_select <= TIME_RST;
      boot_sequence_version_field <= BOOT_RST;
      spare <= SPARE_RST;
      irq_flag <= 1'b0;
      shdn_seen <= 1'b0;
      timeout_shutdown <= 1'b0;
      secs <= 7'h00;
    end else begin
      done <= next_done;
      readdata <= next_readdata;
      supervision_mode_select <= next_mode;
      timeout_period_select <= next_time;
      boot_sequence_version_field <= next_boot;
      spare <= next_spare;
      irq_flag <= next_irq_flag;
      shdn_seen <= next_shdn_seen;
      timeout_shutdown <= next_shutdown;
      secs <= next_secs;
    end
  end

  assign wdog_irq = irq_flag;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_mode_write_takes: assert property (ctrl_wr |=> supervision_mode_select == $past(writedata[MODE_BIT]))
    else $error("mode bit did not follow write");
  a_periodic_irq_raise: assert property (
    supervision_mode_select == MODE_PERIODIC && elapsed && !irq_flag |=> wdog_irq)
    else $error("periodic interrupt not raised");
  a_periodic_miss_shdn: assert property (
    supervision_mode_select == MODE_PERIODIC && elapsed && irq_flag && !irq_clr
    |=> timeout_shutdown ##1 !timeout_shutdown)
    else $error("missed periodic clear without shutdown");
  a_pending_shdn: assert property (
    supervision_mode_select == MODE_PENDING && elapsed && irq_pending |=> timeout_shutdown)
    else $error("pending interrupt outlived period without shutdown");
  a_no_shdn_idle: assert property (
    supervision_mode_select == MODE_PENDING && !irq_pending |=> !timeout_shutdown)
    else $error("shutdown without pending interrupt");
  a_disabled_quiet: assert property (
    timeout_period_select == 3'h0 && $past(timeout_period_select) == 3'h0 |-> !tick && !timeout_shutdown)
    else $error("watchdog active while disabled");
  a_restart_zero: assert property (restart |=> secs == 7'h00)
    else $error("period count not restarted");
  a_bus_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus stalled more than one cycle");
endmodule : pws_top

// >>> verif/pws_host_irq.sv
`timescale 1ns/1ns
// Interrupt source and host handler; raise latches a pending interrupt
module pws_host_irq (
  input wire logic clk, // System clock
  input wire logic rst, // Async reset, active high
  input wire logic raise, // Source asserts an interrupt
  input wire logic clear, // Host services the interrupt
  output logic irq_pending // Pending level to the block
);
  ////////////////////////////////////////////////////////////////
  // Pending holds until the host clears it, as real sources do
  always_ff @(posedge clk or posedge rst) begin
    if (rst) irq_pending <= 1'b0;
    else if (clear) irq_pending <= 1'b0;
    else if (raise) irq_pending <= 1'b1;
  end
endmodule : pws_host_irq

// >>> verif/pws_top_tb.sv
`timescale 1ns/1ns
module pws_top_tb;
  localparam int TC = 4;
  logic clk = 1'b0;
  logic rst, read, write, waitrequest, irq_pending, wdog_irq, timeout_shutdown, raise, clear;
  logic [9:0] address;
  logic [31:0] writedata, readdata, v;
  logic [3:0] byteenable;
  int err_count, comparisons, shd_cnt, n, s;
  pws_top #(.TICK_CYCLES(TC)) dut (.clk(clk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .irq_pending(irq_pending), .wdog_irq(wdog_irq), .timeout_shutdown(timeout_shutdown));
  pws_host_irq host (.clk(clk), .rst(rst), .raise(raise), .clear(clear), .irq_pending(irq_pending));
  ////////////////////////////////////////////////////////////////
  // Clock and shutdown pulse counter; negedge sampling sees the one-cycle pulse settled
  always #10 clk = ~clk;
  always @(negedge clk) if (timeout_shutdown === 1'b1) shd_cnt++;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic print_verdict;
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////
  // One Avalon access; request held until waitrequest is seen low
  task automatic acc(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    int k;
    @(posedge clk);
    address <= {idx, 2'b00};
    writedata <= {24'h0, d};
    read <= !wr;
    write <= wr;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (waitrequest !== 1'b0 && k < 20);
    v = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (k >= 20) begin
      err_count++;
      print_verdict();
    end
  endtask : acc
  // Count cycles until the irq flag (sel=0) or shutdown (sel=1) shows
  task automatic wt(input bit sel, input int lim);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while ((sel ? timeout_shutdown : wdog_irq) !== 1'b1 && n < lim);
    // An event that never shows is a hang: count it and close the run
    if (n >= lim) begin
      err_count++;
      print_verdict();
    end
  endtask : wt
  ////////////////////////////////////////////////////////////////
  // Periodic interrupt after 5 s, then shutdown when left uncleared
  task automatic t_periodic;
    acc(1, 8'h69, 8'h01);
    wt(0, 40);
    chk(n >= 20 && n <= 22, 1, "irq delay");
    wt(1, 40);
    chk(n >= 20 && n <= 22, 1, "shutdown delay");
    acc(0, 8'h70, 8'h00);
    chk(v[1], 1, "shutdown seen");
  endtask : t_periodic
  // Clear in time: no shutdown, next irq a full period after the clear
  task automatic t_clear;
    acc(1, 8'h70, 8'h03);
    acc(1, 8'h69, 8'h01);
    wt(0, 40);
    s = shd_cnt;
    acc(1, 8'h70, 8'h01);
    wt(0, 40);
    chk(n >= 19 && n <= 22, 1, "irq after clear");
    chk(shd_cnt, s, "no shutdown");
  endtask : t_clear
  // Period codes 2 to 7: irq a full period after the control write, then a rewrite restarts the count
  task automatic t_periods;
    int secs_tab[7] = '{5, 10, 20, 40, 60, 80, 100};
    for (int i = 1; i < 7; i++) begin
      acc(1, 8'h70, 8'h03);
      acc(1, 8'h69, 8'(i + 1));
      wt(0, 440);
      chk(n, TC * secs_tab[i] + 1, "irq period");
    end
    acc(1, 8'h70, 8'h03);
    acc(1, 8'h69, 8'h02);
    repeat (30) @(posedge clk);
    acc(1, 8'h69, 8'h02);
    wt(0, 60);
    chk(n, TC * 10 + 1, "irq after rewrite");
  endtask : t_periods
  // Pending mode: stuck interrupt shuts down, period off never does
  task automatic t_pending;
    acc(1, 8'h69, 8'h09);
    acc(0, 8'h69, 8'h00);
    chk(v, 32'h09, "mode readback");
    // A pending interrupt serviced inside the period must not shut down
    s = shd_cnt;
    raise <= 1'b1;
    repeat (10) @(posedge clk);
    raise <= 1'b0;
    clear <= 1'b1;
    @(posedge clk);
    clear <= 1'b0;
    raise <= 1'b1;
    chk(shd_cnt, s, "short pending");
    wt(1, 40);
    raise <= 1'b0;
    chk(n >= 19 && n <= 22, 1, "pending shutdown");
    acc(1, 8'h69, 8'h08);
    s = shd_cnt;
    repeat (60) @(negedge clk);
    chk(shd_cnt, s, "disabled");
    @(posedge clk);
    clear <= 1'b1;
  endtask : t_pending
  ////////////////////////////////////////////////////////////////
  // Reset, then scenarios in order
  initial begin
    rst = 1;
    {read, write, raise, clear} = 4'h0;
    address = 10'h000;
    writedata = 32'h0;
    byteenable = 4'h1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    acc(0, 8'h69, 8'h00);
    chk(v, 32'h0, "ctrl reset");
    chk(wdog_irq, 0, "irq reset");
    t_periodic();
    t_clear();
    t_periods();
    t_pending();
    acc(1, 8'h6a, 8'hff);
    acc(0, 8'h6a, 8'h00);
    chk(v, 32'h3e, "boot version");
    // A write with its low byte lane off must leave the register alone
    byteenable <= 4'h0;
    acc(1, 8'h6a, 8'h00);
    byteenable <= 4'h1;
    acc(0, 8'h6a, 8'h00);
    chk(v, 32'h3e, "masked write");
    acc(0, 8'h7f, 8'h00);
    chk(v, 32'h0, "unmapped");
    print_verdict();
  end
endmodule : pws_top_tb
